// file: core/ssi_map.svh
/*
  register offsets, field positions, reset values and timing counts of
  the receive-only synchronous serial shifter.
  assumes it is included by the modules that need it; the package does not include it.
*/
// Contract
// - data pin becomes input, stays input
// - clock pin becomes driven output
// - two-bit mode picks order and sample point
// - 1 to 16 bits, 8 when none given
// - clock low first, then data to input
// - sample into lsb or msb, pre or post
// - clock high 14 us per bit
// - shift left msb-first, right lsb-first; lsb-first here writes each bit straight into bit bit_cnt instead
// - repeat until bit count collected
// - several destinations per operation, each counted
// - destination width 1, 4, 8 or 16
`ifndef SSI_MAP_SVH
`define SSI_MAP_SVH

`define SSI_CTRL_OFS 8'h00
`define SSI_STATUS_OFS 8'h04
`define SSI_DEST_OFS 8'h10
`define SSI_RESULT_OFS 8'h30

`define SSI_CTRL_START 0
`define SSI_CTRL_MODE 1
`define SSI_CTRL_DPIN 4
`define SSI_CTRL_CPIN 8
`define SSI_CTRL_NDEST 12
`define SSI_STATUS_BUSY 0
`define SSI_STATUS_DONE 1
`define SSI_DEST_COUNT 0
`define SSI_DEST_WIDTH 5

`define SSI_COUNT_DEFAULT 5'h08
`define SSI_COUNT_MAX 5'h10
`define SSI_CTRL_RESET 32'h0000_0100
`define SSI_DEST_RESET 7'h40

`define SSI_PULSE_NS 14000
`define SSI_LINK_PERIOD_NS 32
`define SSI_GAP_CYC 4

`define SSI_RESP_OKAY 2'h0
`define SSI_RESP_SLVERR 2'h2

`endif

// file: core/ssi_pkg.sv
/*
  types of the receive-only synchronous serial shifter.
  assumes nothing beyond the map header.
*/
package ssi_pkg;
  typedef enum logic [1:0] {
    ssi_high_first_sample_before,
    ssi_low_first_sample_before,
    ssi_high_first_sample_after,
    ssi_low_first_sample_after
  } ssi_mode_t;

  typedef enum logic [1:0] {
    ssi_width_1, ssi_width_4, ssi_width_8, ssi_width_16
  } ssi_width_t;

  typedef enum {
    ssi_idle, ssi_clk_low, ssi_data_in, ssi_settle, ssi_high, ssi_fall
  } ssi_state_t;
endpackage

// file: core/ssi_sync.sv
/*
  two-flop synchroniser for a bundle of independent levels.
  assumes each bit is a level that may change at any time.
*/
`timescale 1ns/100ps
module ssi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule

// file: core/ssi_top.sv
/*
  receive-only synchronous serial master with an axi4-lite register
  port on clk_sys and the shift engine on clk_link.
  assumes clk_link is a free-running timebase and that software does
  not rewrite configuration while busy (such writes are dropped).
*/
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "ssi_map.svh"
module ssi_top import ssi_pkg::*; #(
  parameter int NDEST = 4,
  parameter int AW = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_link,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe
);
  localparam int DW = (NDEST > 1) ? $clog2(NDEST) : 1;
  localparam int PULSE_CYC =
    (`SSI_PULSE_NS + `SSI_LINK_PERIOD_NS - 1) / `SSI_LINK_PERIOD_NS;
  localparam logic [8:0] PULSE_LAST = 9'(PULSE_CYC - 1);
  localparam logic [8:0] GAP_LAST = 9'(`SSI_GAP_CYC - 1);

  // register side, clk_sys
  logic aw_got, w_got, busy, done, start_tgl;
  logic [AW-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  ssi_mode_t ctrl_mode;
  logic [3:0] ctrl_dpin, ctrl_cpin;
  logic [DW-1:0] ctrl_ndest;
  logic [4:0] dest_cnt [NDEST];
  ssi_width_t dest_wsel [NDEST];
  logic [15:0] result [NDEST];
  logic done_sync, done_seen;
  logic next_aw_got, next_w_got, next_busy, next_done, next_start_tgl;
  logic [AW-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  ssi_mode_t next_ctrl_mode;
  logic [3:0] next_ctrl_dpin, next_ctrl_cpin;
  logic [DW-1:0] next_ctrl_ndest;
  logic [4:0] next_dest_cnt [NDEST];
  ssi_width_t next_dest_wsel [NDEST];
  logic [15:0] next_result [NDEST];
  logic next_done_seen, next_awready, next_wready, next_bvalid;
  logic next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic done_evt;

  // link side, clk_link
  ssi_state_t state, next_state;
  ssi_mode_t mode_l, next_mode_l;
  logic [3:0] dpin_l, cpin_l, next_dpin_l, next_cpin_l;
  logic [DW-1:0] ndest_l, dest, next_ndest_l, next_dest;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [8:0] wait_cnt, next_wait_cnt;
  logic [15:0] acc, next_acc;
  logic [15:0] res_link [NDEST];
  logic [15:0] next_res_link [NDEST];
  logic [15:0] next_pin_out, next_pin_oe, pin_sync;
  logic start_sync, start_seen, next_start_seen, done_tgl, next_done_tgl;
  logic data_bit, store_now;
  logic [4:0] nbits_cur;

  // word offset check shared by reads and writes
  function automatic logic map_ok(input logic [AW-1:0] a);
    map_ok = (a[1:0] == 2'h0) && ((a == AW'(`SSI_CTRL_OFS)) ||
      (a == AW'(`SSI_STATUS_OFS)) ||
      (a >= AW'(`SSI_DEST_OFS) && a < AW'(`SSI_DEST_OFS + 4 * NDEST)) ||
      (a >= AW'(`SSI_RESULT_OFS) && a < AW'(`SSI_RESULT_OFS + 4 * NDEST)));
  endfunction

  function automatic logic [4:0] nbits(input logic [4:0] c);
    if (c == 5'h00)
      nbits = `SSI_COUNT_DEFAULT;
    else if (c > `SSI_COUNT_MAX)
      nbits = `SSI_COUNT_MAX;
    else
      nbits = c;
  endfunction

  function automatic logic [15:0] wmask(input ssi_width_t w);
    unique case (w)
      ssi_width_1: wmask = 16'h0001;
      ssi_width_4: wmask = 16'h000f;
      ssi_width_8: wmask = 16'h00ff;
      ssi_width_16: wmask = 16'hffff;
    endcase
  endfunction

  ssi_sync #(.W(1)) u_done_sync (
    .clk(clk_sys), .reset_n(reset_n), .d(done_tgl), .q(done_sync));
  ssi_sync #(.W(17)) u_link_sync (
    .clk(clk_link), .reset_n(reset_n), .d({start_tgl, pin_in}),
    .q({start_sync, pin_sync}));

  assign done_evt = done_sync ^ done_seen;

  always_comb begin
    int i;
    logic [AW-1:0] a;
    logic aw_take, w_take;
    i = 0;
    a = '0;
    aw_take = s_axi_awvalid & s_axi_awready;
    w_take = s_axi_wvalid & s_axi_wready;
    next_aw_got = aw_got | aw_take;
    next_w_got = w_got | w_take;
    next_aw_addr = aw_take ? s_axi_awaddr : aw_addr;
    next_w_data = w_take ? s_axi_wdata : w_data;
    next_w_strb = w_take ? s_axi_wstrb : w_strb;
    next_busy = busy;
    next_done = done;
    next_start_tgl = start_tgl;
    next_ctrl_mode = ctrl_mode;
    next_ctrl_dpin = ctrl_dpin;
    next_ctrl_cpin = ctrl_cpin;
    next_ctrl_ndest = ctrl_ndest;
    next_dest_cnt = dest_cnt;
    next_dest_wsel = dest_wsel;
    next_result = result;
    next_done_seen = done_sync;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (aw_got && w_got && !s_axi_bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = map_ok(aw_addr) ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
      if (aw_addr == AW'(`SSI_CTRL_OFS) && !busy) begin
        if (w_strb[0]) begin
          next_ctrl_mode = ssi_mode_t'(w_data[`SSI_CTRL_MODE +: 2]);
          next_ctrl_dpin = w_data[`SSI_CTRL_DPIN +: 4];
          if (w_data[`SSI_CTRL_START]) begin
            next_busy = 1'b1;
            next_start_tgl = ~start_tgl;
          end
        end
        if (w_strb[1]) begin
          next_ctrl_cpin = w_data[`SSI_CTRL_CPIN +: 4];
          next_ctrl_ndest = w_data[`SSI_CTRL_NDEST +: DW];
        end
      end
      if (aw_addr == AW'(`SSI_STATUS_OFS) && w_strb[0] &&
          w_data[`SSI_STATUS_DONE])
        next_done = 1'b0;
      for (i = 0; i < NDEST; i++) begin
        if (aw_addr == AW'(`SSI_DEST_OFS + 4 * i) && w_strb[0] && !busy) begin
          next_dest_cnt[i] = w_data[`SSI_DEST_COUNT +: 5];
          next_dest_wsel[i] = ssi_width_t'(w_data[`SSI_DEST_WIDTH +: 2]);
        end
      end
    end
    // completion wins over a clear written in the same cycle
    if (done_evt) begin
      next_busy = 1'b0;
      next_done = 1'b1;
      next_result = res_link;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      a = s_axi_araddr;
      next_rvalid = 1'b1;
      next_rresp = map_ok(a) ? `SSI_RESP_OKAY : `SSI_RESP_SLVERR;
      next_rdata = 32'h0000_0000;
      if (a == AW'(`SSI_CTRL_OFS))
        next_rdata = 32'({ctrl_ndest, ctrl_cpin, ctrl_dpin, 1'b0,
          ctrl_mode, 1'b0});
      if (a == AW'(`SSI_STATUS_OFS))
        next_rdata = {30'h0, done, busy};
      for (i = 0; i < NDEST; i++) begin
        if (a == AW'(`SSI_DEST_OFS + 4 * i))
          next_rdata = {25'h0, dest_wsel[i], dest_cnt[i]};
        if (a == AW'(`SSI_RESULT_OFS + 4 * i))
          next_rdata = {16'h0, result[i]};
      end
    end
    next_awready = ~next_aw_got & ~next_bvalid;
    next_wready = ~next_w_got & ~next_bvalid;
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      start_tgl <= 1'b0;
      ctrl_mode <= ssi_high_first_sample_before;
      ctrl_dpin <= 4'h0;
      ctrl_cpin <= 4'h1;
      ctrl_ndest <= '0;
      for (int i = 0; i < NDEST; i++) begin
        dest_cnt[i] <= 5'h00;
        dest_wsel[i] <= ssi_width_8;
        result[i] <= 16'h0000;
      end
      done_seen <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      busy <= next_busy;
      done <= next_done;
      start_tgl <= next_start_tgl;
      ctrl_mode <= next_ctrl_mode;
      ctrl_dpin <= next_ctrl_dpin;
      ctrl_cpin <= next_ctrl_cpin;
      ctrl_ndest <= next_ctrl_ndest;
      dest_cnt <= next_dest_cnt;
      dest_wsel <= next_dest_wsel;
      result <= next_result;
      done_seen <= next_done_seen;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // config is quasi-static: held by the sys side while busy
  assign data_bit = pin_sync[dpin_l];
  assign nbits_cur = nbits(dest_cnt[dest]);
  assign store_now = (state == ssi_fall) && (wait_cnt == GAP_LAST) &&
    (bit_cnt == nbits_cur - 5'h01);

  always_comb begin
    logic pre, low_first;
    logic [15:0] cap;
    pre = (mode_l == ssi_high_first_sample_before) ||
      (mode_l == ssi_low_first_sample_before);
    low_first = (mode_l == ssi_low_first_sample_before) ||
      (mode_l == ssi_low_first_sample_after);
    cap = acc;
    if (low_first)
      cap[bit_cnt[3:0]] = data_bit;
    else
      cap = {acc[14:0], data_bit};
    next_state = state;
    next_mode_l = mode_l;
    next_dpin_l = dpin_l;
    next_cpin_l = cpin_l;
    next_ndest_l = ndest_l;
    next_dest = dest;
    next_bit_cnt = bit_cnt;
    next_wait_cnt = wait_cnt;
    next_acc = acc;
    next_res_link = res_link;
    next_pin_out = pin_out;
    next_pin_oe = pin_oe;
    next_start_seen = start_sync;
    next_done_tgl = done_tgl;
    unique case (state)
      ssi_idle: begin
        if (start_sync != start_seen) begin
          next_mode_l = ctrl_mode;
          next_dpin_l = ctrl_dpin;
          next_cpin_l = ctrl_cpin;
          next_ndest_l = ctrl_ndest;
          next_dest = '0;
          next_state = ssi_clk_low;
        end
      end
      ssi_clk_low: begin
        next_pin_oe[cpin_l] = 1'b1;
        next_pin_out[cpin_l] = 1'b0;
        next_state = ssi_data_in;
      end
      ssi_data_in: begin
        next_pin_oe[dpin_l] = 1'b0;
        next_acc = 16'h0000;
        next_bit_cnt = 5'h00;
        next_wait_cnt = 9'h000;
        next_state = ssi_settle;
      end
      ssi_settle: begin
        // gap also covers the two-flop input latency
        if (wait_cnt == GAP_LAST) begin
          next_wait_cnt = 9'h000;
          if (pre)
            next_acc = cap;
          next_pin_out[cpin_l] = 1'b1;
          next_state = ssi_high;
        end else
          next_wait_cnt = wait_cnt + 9'h001;
      end
      ssi_high: begin
        if (wait_cnt == PULSE_LAST) begin
          next_wait_cnt = 9'h000;
          next_pin_out[cpin_l] = 1'b0;
          next_state = ssi_fall;
        end else
          next_wait_cnt = wait_cnt + 9'h001;
      end
      ssi_fall: begin
        if (wait_cnt == GAP_LAST) begin
          next_wait_cnt = 9'h000;
          if (!pre)
            next_acc = cap;
          next_bit_cnt = bit_cnt + 5'h01;
          next_state = ssi_settle;
          if (store_now) begin
            next_res_link[dest] = (pre ? acc : cap) &
              wmask(dest_wsel[dest]);
            next_acc = 16'h0000;
            next_bit_cnt = 5'h00;
            if (dest == ndest_l) begin
              next_done_tgl = ~done_tgl;
              next_state = ssi_idle;
            end else
              next_dest = dest + DW'(1);
          end
        end else
          next_wait_cnt = wait_cnt + 9'h001;
      end
    endcase
  end

  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n) begin
      state <= ssi_idle;
      mode_l <= ssi_high_first_sample_before;
      dpin_l <= 4'h0;
      cpin_l <= 4'h1;
      ndest_l <= '0;
      dest <= '0;
      bit_cnt <= 5'h00;
      wait_cnt <= 9'h000;
      acc <= 16'h0000;
      for (int i = 0; i < NDEST; i++)
        res_link[i] <= 16'h0000;
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
      start_seen <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      state <= next_state;
      mode_l <= next_mode_l;
      dpin_l <= next_dpin_l;
      cpin_l <= next_cpin_l;
      ndest_l <= next_ndest_l;
      dest <= next_dest;
      bit_cnt <= next_bit_cnt;
      wait_cnt <= next_wait_cnt;
      acc <= next_acc;
      res_link <= next_res_link;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      start_seen <= next_start_seen;
      done_tgl <= next_done_tgl;
    end
  end

  // helper: length of the current clock-high run
  logic [9:0] hi_run;
  always_ff @(posedge clk_link or negedge reset_n) begin
    if (!reset_n)
      hi_run <= 10'h000;
    else
      hi_run <= pin_out[cpin_l] ? hi_run + 10'h001 : 10'h000;
  end

  property p_pulse_width;
    @(posedge clk_link) disable iff (!reset_n)
    // hi_run already holds the full run on the edge that sees the fall
    $fell(pin_out[cpin_l]) && state == ssi_fall |->
      hi_run == 10'(PULSE_CYC);
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("clock pulse width wrong");

  property p_order;
    @(posedge clk_link) disable iff (!reset_n)
    state == ssi_clk_low && dpin_l != cpin_l |=>
      pin_oe[cpin_l] && !pin_out[cpin_l] && pin_oe[dpin_l] == $past(
      pin_oe[dpin_l]) ##1 !pin_oe[dpin_l];
  endproperty
  a_order: assert property (p_order)
    else $error("clock not low before data turned input");

  property p_cpin_driven;
    @(posedge clk_link) disable iff (!reset_n)
    state inside {ssi_settle, ssi_high, ssi_fall} |-> pin_oe[cpin_l];
  endproperty
  a_cpin_driven: assert property (p_cpin_driven)
    else $error("clock pin not driven");

  property p_dpin_input;
    @(posedge clk_link) disable iff (!reset_n)
    state inside {ssi_settle, ssi_high, ssi_fall} && dpin_l != cpin_l
      |-> !pin_oe[dpin_l];
  endproperty
  a_dpin_input: assert property (p_dpin_input)
    else $error("data pin driven during receive");

  property p_msb_sample;
    @(posedge clk_link) disable iff (!reset_n)
    state == ssi_settle && wait_cnt == GAP_LAST &&
      mode_l == ssi_high_first_sample_before |=>
      acc[0] == $past(data_bit) && acc[15:1] == $past(acc[14:0]);
  endproperty
  a_msb_sample: assert property (p_msb_sample)
    else $error("msb-first sample or shift wrong");

  property p_count;
    @(posedge clk_link) disable iff (!reset_n)
    state == ssi_high |-> bit_cnt < nbits_cur && nbits_cur != 5'h00;
  endproperty
  a_count: assert property (p_count)
    else $error("bit count exceeded");

  property p_next_dest;
    @(posedge clk_link) disable iff (!reset_n)
    store_now && dest != ndest_l |=>
      state == ssi_settle && dest == $past(dest) + DW'(1);
  endproperty
  a_next_dest: assert property (p_next_dest)
    else $error("destination not advanced");

  property p_upper_zero;
    @(posedge clk_link) disable iff (!reset_n)
    store_now |=> (res_link[$past(dest)] >> $past(nbits_cur)) == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unused result bits not zero");

  property p_end_low;
    @(posedge clk_link) disable iff (!reset_n)
    state == ssi_idle |-> !pin_out[cpin_l];
  endproperty
  a_end_low: assert property (p_end_low)
    else $error("clock left high after operation");

  property p_done_sys;
    @(posedge clk_sys) disable iff (!reset_n)
    done_evt |=> done && !busy;
  endproperty
  a_done_sys: assert property (p_done_sys)
    else $error("completion not reported");

  c_low_after: cover property (@(posedge clk_link) disable iff (!reset_n)
    store_now && mode_l == ssi_low_first_sample_after);
  c_multi: cover property (@(posedge clk_link) disable iff (!reset_n)
    store_now && dest != '0);
  c_sixteen: cover property (@(posedge clk_link) disable iff (!reset_n)
    store_now && nbits_cur == 5'h10);
endmodule

// file: testbench/ssi_peer.sv
/*
  model of the shift-register peer that feeds the serial data line.
  assumes sclk reads low when not driven and load pulses before each op.
*/
`timescale 1ns/100ps
module ssi_peer (
  input wire logic load,
  input wire logic [31:0] seed,
  input wire logic sclk,
  output logic sdo
);
  logic [31:0] sr;
  // one bit per rising clock, bucket-brigade style
  always @(posedge sclk or posedge load) begin
    if (load)
      sr <= seed;
    else
      sr <= {sr[30:0], ~sr[0]};
  end
  assign sdo = sr[31];
endmodule

// file: testbench/ssi_top_tb.sv
/*
  self-checking bench for ssi_top: axi4-lite master tasks and scenarios.
  assumes the peer model and a 32 ns link clock of unrelated phase.
*/
`timescale 1ns/100ps
module ssi_top_tb;
  import ssi_pkg::*;
  localparam logic [31:0] PAT = 32'hC5A3_96E1;
  localparam logic [3:0] DPIN = 4'h3;
  localparam logic [3:0] CPIN = 4'h9;
  logic clk_sys = 0, clk_link = 0, reset_n = 0, load = 0, tog = 0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sdo;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] pin_in, pin_out, pin_oe;
  int num_errors = 0, cmp_count = 0, cyc = 0, hi_cnt = 0, hi_last = 0;

  always #2 clk_sys = ~clk_sys;
  // phase offset keeps the two clocks unrelated
  initial begin
    #0.7;
    forever #16 clk_link = ~clk_link;
  end

  ssi_top i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_link(clk_link),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // undriven clock line is taken as pulled low
  ssi_peer i_peer (
    .load(load), .seed(PAT), .sclk(pin_oe[CPIN] & pin_out[CPIN]),
    .sdo(sdo)
  );

  // idle lines wiggle so a stale sample cannot pass by luck
  always_comb begin
    for (int i = 0; i < 16; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : tog ^ i[0];
    if (!pin_oe[DPIN])
      pin_in[DPIN] = sdo;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    tog <= ~tog;
    if (pin_oe[CPIN] && pin_out[CPIN])
      hi_cnt <= hi_cnt + 1;
    else if (hi_cnt != 0) begin
      hi_last <= hi_cnt;
      hi_cnt <= 0;
    end
    if (cyc == 99000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // bits off..off+n-1 of the peer stream, packed as the mode says
  function automatic logic [15:0] expv(int off, int n, logic lsbf, int w);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      if (lsbf)
        v[i] = PAT[31-off-i];
      else
        v = {v[14:0], PAT[31-off-i]};
    end
    return v & 16'((1 << w) - 1);
  endfunction

  task automatic run_op(input logic [1:0] mode, input logic [1:0] nd);
    logic [31:0] st;
    logic [1:0] r;
    @(posedge clk_sys);
    load <= 1'b1;
    @(posedge clk_sys);
    load <= 1'b0;
    wr(8'h00, {18'h0_0000, nd, CPIN, DPIN, 1'b0, mode, 1'b1}, r);
    do
      rd(8'h04, st, r);
    while (st[1] !== 1'b1);
    chk("clk_oe", 32'h1, {31'h0000_0000, pin_oe[CPIN]});
    chk("data_oe", 32'h0, {31'h0000_0000, pin_oe[DPIN]});
    chk("clk_idle", 32'h0, {31'h0000_0000, pin_out[CPIN]});
    chk("pulse", 32'h1, {31'h0000_0000, hi_last inside {[3500:3512]}});
    wr(8'h04, 32'h0000_0002, r);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d, r);
    chk("ctrl_rst", 32'h0000_0100, d);
    rd(8'h10, d, r);
    chk("dest_rst", 32'h0000_0040, d);
    rd(8'h04, d, r);
    chk("status_rst", 32'h0000_0000, d);
    chk("pin_oe_rst", 32'h0000_0000, {16'h0000, pin_oe});
    rd(8'h08, d, r);
    chk("unmapped_rresp", 32'h2, {30'h0000_0000, r});
    wr(8'h08, 32'hFFFF_FFFF, r);
    chk("unmapped_bresp", 32'h2, {30'h0000_0000, r});
  endtask

  // every mode, every width, three bits each
  task automatic t_modes();
    logic [31:0] d;
    logic [1:0] r;
    int w[4] = '{1, 4, 8, 16};
    for (int m = 0; m < 4; m++) begin
      wr(8'h10, 32'(m * 32 + 3), r);
      run_op(2'(m), 2'h0);
      rd(8'h30, d, r);
      chk("mode_res", {16'h0000, expv(m / 2, 3, m % 2, w[m])}, d);
    end
  endtask

  // chained read: default count into a word, then two bits into one bit
  task automatic t_multi();
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h10, 32'h0000_0060, r);
    wr(8'h14, 32'h0000_0002, r);
    run_op(2'h0, 2'h1);
    rd(8'h30, d, r);
    chk("dest0", {16'h0000, expv(0, 8, 1'b0, 16)}, d);
    rd(8'h34, d, r);
    chk("dest1", {16'h0000, expv(8, 2, 1'b0, 1)}, d);
  endtask

  initial begin
    repeat (2) @(posedge clk_link);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_modes();
    t_multi();
    finish_test();
  end
endmodule
